// ---- src/srx_pkg.sv ----
// Package with register map, field layout and states of the exit controller.
package srx_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed index of the transition register; byte address is four times it.
  localparam logic [7:0] CFG_INDEX   = 8'h37;
  localparam logic [9:0] CFG_ADDR    = {CFG_INDEX, 2'b00};
  // Control register: start, stop, low-power route and idle chip mode.
  localparam logic [9:0] CTRL_ADDR   = 10'h0F0;
  // Status register: current state, chip mode and sticky timeout bit.
  localparam logic [9:0] STAT_ADDR   = 10'h0F4;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int RX_SEL_LSB  = 5;       // Exit from Receive, bits 7..5.
  localparam int TMO_SEL_LSB = 3;       // Exit on timeout, bits 4..3.
  localparam int PKT_SEL_LSB = 0;       // Exit from packet done, bits 2..0.
  localparam int CTRL_START  = 0;       // Write one to start in Receive.
  localparam int CTRL_STOP   = 1;       // Write one to force halt.
  localparam int CTRL_ROUTE  = 2;       // Low-power route: 0 off, 1 idle.
  localparam int CTRL_IDLE   = 3;       // Idle chip mode: 0 standby, 1 sleep.
  localparam int STAT_TMO    = 4;       // Sticky timeout, write one to clear.

  // ****************************************************************
  // Selector codes
  // ****************************************************************
  localparam logic [2:0] RX_PAYLOAD_DONE = 3'h1;
  localparam logic [2:0] RX_PAYLOAD_LP   = 3'h2;
  localparam logic [2:0] RX_CHECKSUM     = 3'h3;
  localparam logic [2:0] RX_STRENGTH     = 3'h4;
  localparam logic [2:0] RX_SYNC         = 3'h5;
  localparam logic [2:0] RX_PREAMBLE     = 3'h6;
  localparam logic [1:0] TMO_RESTART     = 2'h0;
  localparam logic [1:0] TMO_TRANSMIT    = 2'h1;
  localparam logic [1:0] TMO_LOW_POWER   = 2'h2;
  localparam logic [1:0] TMO_HALT        = 2'h3;
  localparam logic [2:0] PKT_HALT        = 3'h0;
  localparam logic [2:0] PKT_TRANSMIT    = 3'h1;
  localparam logic [2:0] PKT_LOW_POWER   = 3'h2;
  localparam logic [2:0] PKT_VIA_SYNTH   = 3'h3;
  localparam logic [2:0] PKT_RECEIVE     = 3'h4;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_HALTED  = 3'h0,
    ST_RECEIVE = 3'h1,
    ST_PKTDONE = 3'h2,
    ST_TX      = 3'h3,
    ST_IDLE    = 3'h4,
    ST_RESTART = 3'h5,
    ST_SYNTH   = 3'h6
  } srx_state_t;

endpackage : srx_pkg

// ---- src/srx_regs.sv ----
// Storage for the transition and control registers of the exit controller.
`timescale 1ns/1ps
module srx_regs (
  input  wire logic       pclk,      // System clock.
  input  wire logic       presetn,   // Asynchronous reset, active low.
  input  wire logic       cfg_we,    // Write strobe for transition register.
  input  wire logic       ctrl_we,   // Write strobe for control register.
  input  wire logic [7:0] wdata,     // Write data, low byte of the bus.
  output logic      [7:0] cfg_q,     // Transition register contents.
  output logic      [1:0] ctrl_q     // Route and idle mode bits.
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] cfg_reg;               // Three selector fields.
  logic [1:0] ctrl_reg;              // Stored control bits only.

  // Both registers load only on the access edge chosen by the bus slave.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg  <= srx_pkg::CFG_RESET;
      ctrl_reg <= 2'h0;
    end else begin
      if (cfg_we) begin
        cfg_reg <= wdata;
      end
      if (ctrl_we) begin
        ctrl_reg <= {wdata[srx_pkg::CTRL_IDLE], wdata[srx_pkg::CTRL_ROUTE]};
      end
    end
  end

  assign cfg_q  = cfg_reg;
  assign ctrl_q = ctrl_reg;

endmodule : srx_regs

// ---- src/srx_exit_ctrl.sv ----
// Receive and packet-done exit controller of the mode sequencer, APB slave.
`timescale 1ns/1ps

// Functional notes
// - Bits 7..5 pick Receive exit; 000/111 none
// - Code 001: payload done goes packet done
// - Code 010: payload done takes low-power route
// - Code 011: checksum pass goes packet done
// - Codes 100/101/110 halt on strength/sync/preamble
// - Bits 4..3 route timeout, and payload at 011
// - Timeout codes: restart, transmit, low-power, halt
// - Any of three wait timeouts is timeout
// - Bits 2..0 pick packet exit; 000 halt, 010 low-power
// - Packet code 001: queue empty goes transmit
// - 011 via synth if retuned; 100 straight Receive
// - Low-power route: halted, or idle standby/sleep
module srx_exit_ctrl (
  input  wire logic        pclk,                  // System clock, 50 MHz.
  input  wire logic        presetn,               // Async reset, active low.
  input  wire logic        psel,                  // APB select.
  input  wire logic        penable,               // APB access phase.
  input  wire logic        pwrite,                // APB direction, 1 write.
  input  wire logic [9:0]  paddr,                 // APB byte address.
  input  wire logic [31:0] pwdata,                // APB write data.
  output logic      [31:0] prdata,                // APB read data.
  output logic             pready,                // APB ready.
  output logic             pslverr,               // APB error, unmapped.
  input  wire logic        payload_complete_flag, // Payload ready event.
  input  wire logic        checksum_pass_flag,    // Checksum good event.
  input  wire logic        signal_strength_flag,  // Signal strength event.
  input  wire logic        sync_word_match_flag,  // Sync word event.
  input  wire logic        preamble_seen_flag,    // Preamble event.
  input  wire logic        rssi_wait_timeout,     // Strength wait expired.
  input  wire logic        preamble_wait_timeout, // Preamble wait expired.
  input  wire logic        sync_wait_timeout,     // Sync wait expired.
  input  wire logic        queue_empty_flag,      // Data queue empty event.
  input  wire logic        freq_changed,          // Carrier was retuned.
  output logic [2:0]       seq_state,             // Current sequencer state.
  output logic             chip_sleep,            // Idle in sleep mode.
  output logic             receive_timeout_event  // Timeout pulse, registered copy of the timers.
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Resolve the low-power route into its final state.
  function automatic srx_pkg::srx_state_t lp_target(input logic route);
    lp_target = route ? srx_pkg::ST_IDLE : srx_pkg::ST_HALTED;
  endfunction : lp_target

  // Resolve a timeout selector code into its next state.
  function automatic srx_pkg::srx_state_t tmo_target(input logic [1:0] sel,
                                                     input logic route);
    unique case (sel)
      srx_pkg::TMO_RESTART:   tmo_target = srx_pkg::ST_RESTART;
      srx_pkg::TMO_TRANSMIT:  tmo_target = srx_pkg::ST_TX;
      srx_pkg::TMO_LOW_POWER: tmo_target = lp_target(route);
      srx_pkg::TMO_HALT:      tmo_target = srx_pkg::ST_HALTED;
    endcase
  endfunction : tmo_target

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [31:0] prdata_reg;            // Registered read data.
  logic        pready_reg;            // Ready, one wait state.
  logic        pslverr_reg;           // Error for unmapped address.
  logic [7:0]  cfg_q;                 // Transition register.
  logic [1:0]  ctrl_q;                // Route and idle bits.
  logic        tmo_sticky_reg;        // Sticky timeout status.
  logic        tmo_pulse_reg;         // Registered timeout pulse.
  srx_pkg::srx_state_t state_reg;     // Sequencer state.
  srx_pkg::srx_state_t state_next;    // Next sequencer state.

  wire        acc_wait  = psel && penable && !pready_reg; // Wait state.
  wire        acc_done  = psel && penable && pready_reg;  // Completing edge.
  wire        hit_cfg   = (paddr == srx_pkg::CFG_ADDR);
  wire        hit_ctrl  = (paddr == srx_pkg::CTRL_ADDR);
  wire        hit_stat  = (paddr == srx_pkg::STAT_ADDR);
  wire        mapped    = hit_cfg || hit_ctrl || hit_stat;
  wire        wr_done   = acc_done && pwrite && mapped;
  wire        cfg_we    = wr_done && hit_cfg;
  wire        ctrl_we   = wr_done && hit_ctrl;
  wire        stat_we   = wr_done && hit_stat;
  wire        start_cmd = ctrl_we && pwdata[srx_pkg::CTRL_START];
  wire        stop_cmd  = ctrl_we && pwdata[srx_pkg::CTRL_STOP];
  wire        tmo_clr   = stat_we && pwdata[srx_pkg::STAT_TMO];
  wire [31:0] stat_word = {27'h000_0000, tmo_sticky_reg, chip_sleep,
                           state_reg};
  wire [31:0] ctrl_word = {28'h000_0000, ctrl_q, 2'h0};
  wire [31:0] rd_word   = hit_cfg  ? {24'h00_0000, cfg_q} :
                          hit_ctrl ? ctrl_word :
                          hit_stat ? stat_word : 32'h0000_0000;

  // Field selectors taken from the transition register and the control register.
  wire [2:0]  rx_exit_select           = cfg_q[srx_pkg::RX_SEL_LSB +: 3];
  wire [1:0]  rx_timeout_exit_select   = cfg_q[srx_pkg::TMO_SEL_LSB +: 2];
  wire [2:0]  pkt_received_exit_select = cfg_q[srx_pkg::PKT_SEL_LSB +: 3];
  wire        route_bit                = ctrl_q[0];
  wire        idle_chip_mode           = ctrl_q[1];

  // Any of the three wait timers counts as a receive timeout.
  wire        rx_timeout = rssi_wait_timeout || preamble_wait_timeout ||
                           sync_wait_timeout;

  // Register storage lives in its own small module.
  srx_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg_we  (cfg_we),
    .ctrl_we (ctrl_we),
    .wdata   (pwdata[7:0]),
    .cfg_q   (cfg_q),
    .ctrl_q  (ctrl_q)
  );

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Every access takes one wait state; the read word is captured in the
  // first access cycle so it is stable while pready is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc_wait;
      pslverr_reg <= acc_wait && !mapped;
      if (acc_wait && !pwrite) begin
        prdata_reg <= rd_word;
      end
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // A timeout is checked before the data events, so a receive window that
  // expires in the same cycle as a late event still leaves by the timeout.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      srx_pkg::ST_RECEIVE: begin
        if (rx_timeout) begin
          state_next = tmo_target(rx_timeout_exit_select, route_bit);
        end else begin
          unique case (rx_exit_select)
            srx_pkg::RX_PAYLOAD_DONE: begin
              if (payload_complete_flag) begin
                state_next = srx_pkg::ST_PKTDONE;
              end
            end
            srx_pkg::RX_PAYLOAD_LP: begin
              if (payload_complete_flag) begin
                state_next = lp_target(route_bit);
              end
            end
            srx_pkg::RX_CHECKSUM: begin
              if (checksum_pass_flag) begin
                state_next = srx_pkg::ST_PKTDONE;
              end else if (payload_complete_flag) begin
                // Payload without a good checksum follows the timeout field.
                state_next = tmo_target(rx_timeout_exit_select,
                                        route_bit);
              end
            end
            srx_pkg::RX_STRENGTH: begin
              if (signal_strength_flag) begin
                state_next = srx_pkg::ST_HALTED;
              end
            end
            srx_pkg::RX_SYNC: begin
              if (sync_word_match_flag) begin
                state_next = srx_pkg::ST_HALTED;
              end
            end
            srx_pkg::RX_PREAMBLE: begin
              // The doubly defined code is taken as the preamble exit.
              if (preamble_seen_flag) begin
                state_next = srx_pkg::ST_HALTED;
              end
            end
            default: begin
              // Codes 000 and 111 leave the sequencer where it is.
              state_next = state_reg;
            end
          endcase
        end
      end
      srx_pkg::ST_PKTDONE: begin
        unique case (pkt_received_exit_select)
          srx_pkg::PKT_HALT:      state_next = srx_pkg::ST_HALTED;
          srx_pkg::PKT_TRANSMIT: begin
            if (queue_empty_flag) begin
              state_next = srx_pkg::ST_TX;
            end
          end
          srx_pkg::PKT_LOW_POWER: state_next = lp_target(route_bit);
          srx_pkg::PKT_VIA_SYNTH: begin
            state_next = freq_changed ? srx_pkg::ST_SYNTH
                                      : srx_pkg::ST_RECEIVE;
          end
          srx_pkg::PKT_RECEIVE:   state_next = srx_pkg::ST_RECEIVE;
          default:                state_next = state_reg;
        endcase
      end
      // Restart and synth-only are one-cycle passes back into Receive.
      srx_pkg::ST_RESTART: state_next = srx_pkg::ST_RECEIVE;
      srx_pkg::ST_SYNTH:   state_next = srx_pkg::ST_RECEIVE;
      // Halted, idle and transmit exits belong to neighbouring logic.
      srx_pkg::ST_HALTED:  state_next = state_reg;
      srx_pkg::ST_IDLE:    state_next = state_reg;
      srx_pkg::ST_TX:      state_next = state_reg;
      default:             state_next = srx_pkg::ST_HALTED;
    endcase
  end

  // ****************************************************************
  // State and status registers
  // ****************************************************************
  // Stop beats start, and both beat the event-driven transitions, so that
  // software can always force the sequencer off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= srx_pkg::ST_HALTED;
    end else if (stop_cmd) begin
      state_reg <= srx_pkg::ST_HALTED;
    end else if (start_cmd) begin
      state_reg <= srx_pkg::ST_RECEIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // The timeout pulse follows the timers in every state; the sticky copy
  // lets a set in the clearing cycle win over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_pulse_reg  <= 1'b0;
      tmo_sticky_reg <= 1'b0;
    end else begin
      tmo_pulse_reg <= rx_timeout;
      if (rx_timeout) begin
        tmo_sticky_reg <= 1'b1;
      end else if (tmo_clr) begin
        tmo_sticky_reg <= 1'b0;
      end
    end
  end

  // Chip mode output: sleep only while idling with sleep selected.
  logic chip_sleep_reg;                 // Registered chip mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_sleep_reg <= 1'b0;
    end else begin
      chip_sleep_reg <= (state_next == srx_pkg::ST_IDLE) &&
                        idle_chip_mode && !stop_cmd && !start_cmd;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata                = prdata_reg;
  assign pready                = pready_reg;
  assign pslverr               = pslverr_reg;
  assign seq_state             = state_reg;
  assign chip_sleep            = chip_sleep_reg;
  assign receive_timeout_event = tmo_pulse_reg;

endmodule : srx_exit_ctrl

// ---- testbench/srx_exit_chk.sv ----
// Checker of the exit controller's state transitions and timeout pulse.
`timescale 1ns/1ps
module srx_exit_chk (
  input wire logic        pclk,                  // Clock.
  input wire logic        presetn,               // Reset, active low.
  input wire logic        psel,                  // APB select.
  input wire logic        penable,               // APB enable.
  input wire logic        pwrite,                // APB write.
  input wire logic [9:0]  paddr,                 // APB address.
  input wire logic [31:0] pwdata,                // APB write data.
  input wire logic        pready,                // APB ready.
  input wire logic        payload_complete_flag, // Payload event.
  input wire logic        checksum_pass_flag,    // Checksum event.
  input wire logic        signal_strength_flag,  // Strength event.
  input wire logic        sync_word_match_flag,  // Sync event.
  input wire logic        preamble_seen_flag,    // Preamble event.
  input wire logic        rssi_wait_timeout,     // Wait timeout.
  input wire logic        preamble_wait_timeout, // Wait timeout.
  input wire logic        sync_wait_timeout,     // Wait timeout.
  input wire logic        queue_empty_flag,      // Queue empty event.
  input wire logic        freq_changed,          // Carrier retuned.
  input wire logic [2:0]  seq_state,             // Sequencer state.
  input wire logic        receive_timeout_event  // Timeout pulse.
);
  logic [7:0] cfg_sh;   // Shadow of the transition register.
  logic       route_sh; // Shadow of the low-power route bit.
  logic [2:0] lp;       // Where the low-power route ends.
  logic [2:0] tmo_dst;  // Exit on a timeout.
  logic [2:0] pkt_dst;  // Exit from packet done.
  wire wr_done = psel & penable & pready & pwrite;
  // Start and stop writes override every exit, so they mask the checks.
  wire ctl_wr = wr_done & (paddr == srx_pkg::CTRL_ADDR);
  wire tmo_any = rssi_wait_timeout | preamble_wait_timeout | sync_wait_timeout;
  wire in_rx = (seq_state == srx_pkg::ST_RECEIVE) & !ctl_wr;
  wire [2:0] rx = cfg_sh[7:5];
  wire [2:0] pk = cfg_sh[2:0];
  wire hit = (rx == 3'h4 & signal_strength_flag) |
             (rx == 3'h5 & sync_word_match_flag) |
             (rx == 3'h6 & preamble_seen_flag);
  assign lp = route_sh ? srx_pkg::ST_IDLE : srx_pkg::ST_HALTED;
  assign tmo_dst = cfg_sh[4:3] == 2'h0 ? srx_pkg::ST_RESTART :
                   cfg_sh[4:3] == 2'h1 ? srx_pkg::ST_TX :
                   cfg_sh[4:3] == 2'h2 ? lp : srx_pkg::ST_HALTED;
  assign pkt_dst = pk == 3'h0 ? srx_pkg::ST_HALTED :
    pk == 3'h1 ? (queue_empty_flag ? srx_pkg::ST_TX : srx_pkg::ST_PKTDONE) :
    pk == 3'h2 ? lp :
    pk == 3'h3 ? (freq_changed ? srx_pkg::ST_SYNTH : srx_pkg::ST_RECEIVE) :
    pk == 3'h4 ? srx_pkg::ST_RECEIVE : srx_pkg::ST_PKTDONE;

  // Shadow copies follow completed writes, at the same edge as the design.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_sh   <= 8'h00;
      route_sh <= 1'b0;
    end else if (wr_done) begin
      if (paddr == srx_pkg::CFG_ADDR) cfg_sh <= pwdata[7:0];
      if (ctl_wr) route_sh <= pwdata[srx_pkg::CTRL_ROUTE];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Receive state with no timeout pending is where data events count.
  sequence s_calm;
    in_rx && !tmo_any;
  endsequence

  a_tmo_pulse: assert property (
      1 |=> receive_timeout_event == $past(tmo_any))
    else $error("timeout pulse wrong");
  a_rx_unused: assert property (
      s_calm ##0 (rx == 3'h0 || rx == 3'h7) |=>
      seq_state == srx_pkg::ST_RECEIVE)
    else $error("unused code left receive");
  a_rx_payload: assert property (
      s_calm ##0 (rx == 3'h1 && payload_complete_flag) |=>
      seq_state == srx_pkg::ST_PKTDONE)
    else $error("payload exit wrong");
  a_rx_lowpwr: assert property (
      s_calm ##0 (rx == 3'h2 && payload_complete_flag) |=> seq_state == lp)
    else $error("low-power exit wrong");
  a_rx_checksum: assert property (
      s_calm ##0 (rx == 3'h3 && checksum_pass_flag) |=>
      seq_state == srx_pkg::ST_PKTDONE)
    else $error("checksum exit wrong");
  a_rx_halt: assert property (
      s_calm ##0 hit |=> seq_state == srx_pkg::ST_HALTED)
    else $error("halt exit wrong");
  a_tmo_exit: assert property (
      in_rx && (tmo_any || (rx == 3'h3 && payload_complete_flag &&
      !checksum_pass_flag)) |=> seq_state == $past(tmo_dst))
    else $error("timeout exit wrong");
  a_pass_back: assert property (
      (seq_state == srx_pkg::ST_RESTART || seq_state == srx_pkg::ST_SYNTH) &&
      !ctl_wr |=> seq_state == srx_pkg::ST_RECEIVE)
    else $error("no return to receive");
  a_pkt_exit: assert property (
      seq_state == srx_pkg::ST_PKTDONE && !ctl_wr |=>
      seq_state == $past(pkt_dst))
    else $error("packet exit wrong");
endmodule : srx_exit_chk

bind srx_exit_ctrl srx_exit_chk srx_exit_chk_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .payload_complete_flag,
  .checksum_pass_flag, .signal_strength_flag, .sync_word_match_flag,
  .preamble_seen_flag, .rssi_wait_timeout, .preamble_wait_timeout,
  .sync_wait_timeout, .queue_empty_flag, .freq_changed, .seq_state,
  .receive_timeout_event);

// ---- testbench/srx_exit_ctrl_bench.sv ----
// Self-checking bench of the receive exit controller over APB.
`timescale 1ns/1ps
module srx_exit_ctrl_bench;
  logic        pclk = 1'b0;     // Clock, 50 MHz.
  logic        presetn = 1'b0;  // Reset, active low.
  logic        psel = 1'b0;     // APB request lines.
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;    // Read data and its captured copy.
  logic        pready, pslverr, rerr;
  logic [9:0]  ev = 10'h000;    // Event and level inputs, one bit each.
  logic [2:0]  seq_state;
  logic        chip_sleep, receive_timeout_event;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;

  srx_exit_ctrl srx_exit_ctrl_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .payload_complete_flag(ev[0]), .checksum_pass_flag(ev[1]),
    .signal_strength_flag(ev[2]), .sync_word_match_flag(ev[3]),
    .preamble_seen_flag(ev[4]), .rssi_wait_timeout(ev[5]),
    .preamble_wait_timeout(ev[6]), .sync_wait_timeout(ev[7]),
    .queue_empty_flag(ev[8]), .freq_changed(ev[9]), .seq_state,
    .chip_sleep, .receive_timeout_event);

  initial begin
    forever #10 pclk = ~pclk;
  end

  // A hang ends the run well past the few hundred cycles it needs.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait that never sees pready.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Programs the exits, starts in Receive, pulses events for one cycle.
  task run(input logic [7:0] cfg, ctl, m, input logic [2:0] exp);
    apb(1'b1, srx_pkg::CFG_ADDR, 32'(cfg));
    apb(1'b1, srx_pkg::CTRL_ADDR, 32'(ctl | 8'h01));
    @(posedge pclk);
    ev[7:0] <= m;
    @(posedge pclk);
    ev[7:0] <= 8'h00;
    #1;
    chk("seq_state", 32'(seq_state), 32'(exp));
    chk("timeout_event", 32'(receive_timeout_event), 32'(|m[7:5]));
  endtask : run

  // Reaches packet done, then judges its exit with levels held.
  task pk(input logic [7:0] cfg, input logic [1:0] lv, input logic [2:0] exp);
    @(posedge pclk);
    ev[9:8] <= lv;
    run(cfg, 8'h00, 8'h01, srx_pkg::ST_PKTDONE);
    @(posedge pclk);
    #1;
    chk("pkt_exit", 32'(seq_state), 32'(exp));
  endtask : pk

  task t_regs;
    apb(1'b0, srx_pkg::CFG_ADDR, 32'h0000_0000);
    chk("cfg_reset", rdat, 32'(srx_pkg::CFG_RESET));
    apb(1'b0, srx_pkg::STAT_ADDR, 32'h0000_0000);
    chk("stat_reset", rdat, 32'h0000_0000);
    apb(1'b1, srx_pkg::CFG_ADDR, 32'hFFFF_FFA5);
    apb(1'b1, 10'h100, 32'h0000_005A);
    chk("unmapped_err", 32'(rerr), 32'h0000_0001);
    apb(1'b0, 10'h100, 32'h0000_0000);
    chk("unmapped_data", rdat, 32'h0000_0000);
    apb(1'b0, srx_pkg::CFG_ADDR, 32'h0000_0000);
    chk("cfg_rw", rdat, 32'h0000_00A5);
    apb(1'b1, srx_pkg::CTRL_ADDR, 32'h0000_0001);
    #1;
    chk("start", 32'(seq_state), 32'(srx_pkg::ST_RECEIVE));
    apb(1'b1, srx_pkg::CTRL_ADDR, 32'h0000_0003);
    #1;
    chk("stop_wins", 32'(seq_state), 32'(srx_pkg::ST_HALTED));
  endtask : t_regs

  task t_rx;
    run(8'h05, 8'h00, 8'h01, srx_pkg::ST_RECEIVE);
    run(8'hE5, 8'h00, 8'h11, srx_pkg::ST_RECEIVE);
    run(8'h25, 8'h00, 8'h01, srx_pkg::ST_PKTDONE);
    run(8'h45, 8'h00, 8'h01, srx_pkg::ST_HALTED);
    run(8'h45, 8'h04, 8'h01, srx_pkg::ST_IDLE);
    run(8'h45, 8'h0C, 8'h01, srx_pkg::ST_IDLE);
    @(posedge pclk);
    #1;
    chk("chip_sleep", 32'(chip_sleep), 32'h0000_0001);
    run(8'h7D, 8'h00, 8'h02, srx_pkg::ST_PKTDONE);
    run(8'h85, 8'h00, 8'h04, srx_pkg::ST_HALTED);
    run(8'h85, 8'h00, 8'h01, srx_pkg::ST_RECEIVE);
    run(8'hA5, 8'h00, 8'h08, srx_pkg::ST_HALTED);
    run(8'hC5, 8'h00, 8'h10, srx_pkg::ST_HALTED);
  endtask : t_rx

  task t_tmo;
    run(8'h7D, 8'h00, 8'h01, srx_pkg::ST_HALTED);
    run(8'h6D, 8'h00, 8'h01, srx_pkg::ST_TX);
    run(8'h25, 8'h00, 8'h21, srx_pkg::ST_RESTART);
    run(8'h2D, 8'h00, 8'h40, srx_pkg::ST_TX);
    run(8'h35, 8'h04, 8'h80, srx_pkg::ST_IDLE);
    run(8'h3D, 8'h00, 8'h20, srx_pkg::ST_HALTED);
    apb(1'b0, srx_pkg::STAT_ADDR, 32'h0000_0000);
    chk("stat_sticky", rdat, 32'h0000_0010);
    apb(1'b1, srx_pkg::STAT_ADDR, 32'h0000_0010);
    apb(1'b0, srx_pkg::STAT_ADDR, 32'h0000_0000);
    chk("stat_clear", rdat, 32'h0000_0000);
  endtask : t_tmo

  task t_pkt;
    pk(8'h20, 2'b00, srx_pkg::ST_HALTED);
    pk(8'h21, 2'b01, srx_pkg::ST_TX);
    pk(8'h21, 2'b00, srx_pkg::ST_PKTDONE);
    pk(8'h22, 2'b00, srx_pkg::ST_HALTED);
    pk(8'h23, 2'b10, srx_pkg::ST_SYNTH);
    pk(8'h24, 2'b00, srx_pkg::ST_RECEIVE);
    pk(8'h25, 2'b00, srx_pkg::ST_PKTDONE);
    pk(8'h27, 2'b00, srx_pkg::ST_PKTDONE);
  endtask : t_pkt

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rx();
    t_tmo();
    t_pkt();
    complete_run();
  end
endmodule : srx_exit_ctrl_bench
